// file: cbcs_fifo.sv
// Request buffer between the core and the bus sequencer
module cbcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rstN,
  // Filling side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Draining side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0]   count;
  } cbcs_fifo_st_t;

  cbcs_fifo_st_t st;
  cbcs_fifo_st_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign inReady  = (st.count != (AW+1)'(DEPTH));
  assign outValid = (st.count != '0);
  assign outData  = mem[st.rd];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + AW'(1);
    end
    if (pop) begin
      next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + AW'(1);
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage has no reset; contents only matter below count
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[st.wr] <= inData;
    end
  end
endmodule

// file: cbcs_mem_model.sv
// Memory-side model: one transfer per cycle, programmable wait states
module cbcs_mem_model
  import cbcs_pkg::*;
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // Bus from the sequencer
  input  wire logic                  address_strobe_n,
  input  wire cbcs_pkg::cbcs_addr_t  busAddr,
  // Scenario controls
  input  wire logic [5:0]            waitN,
  input  wire logic                  naEn,
  // Answers
  output logic                       transfer_ready_n,
  output logic                       next_address_req_n,
  output logic [cbcs_pkg::DATA_W-1:0] memData
);
  logic [ADDR_W-1:0] pend[$];
  logic [5:0]        waited;
  //////////////////////////////////////////////////////////////////////////
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pend.delete();
      waited <= '0;
      transfer_ready_n <= 1'b1;
      next_address_req_n <= 1'b1;
      memData <= '0;
    end else begin
      if (!address_strobe_n)
        pend.push_back(busAddr.addr);
      if (pend.size() > 0 && waited >= waitN) begin
        transfer_ready_n <= 1'b0;
        memData <= {pend[0], 6'h2a, ~pend[0]};
        void'(pend.pop_front());
        waited <= '0;
      end else begin
        // Wait state; released bus shows a pattern, not the last value
        transfer_ready_n <= 1'b1;
        memData <= ~memData;
        if (pend.size() > 0)
          waited <= waited + 6'h1;
      end
      next_address_req_n <= !(naEn && pend.size() > 0);
    end
  end
endmodule

// file: cbcs_pkg.sv
// Package of types and constants for the bus cycle sequencer
package cbcs_pkg;
  localparam int ADDR_W = 29;
  localparam int DATA_W = 64;
  localparam int BE_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int MAX_OUTSTANDING = 3;
  localparam int BURST_LEN = 4;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic [7:0] SPC_WB_INV = 8'hf7;
  localparam logic [7:0] SPC_HALT = 8'hfb;
  localparam logic [7:0] SPC_INV = 8'hfd;
  localparam logic [7:0] SPC_SHUTDOWN = 8'hfe;
  localparam logic [7:0] BE_ALL = 8'h00;

  typedef enum logic [2:0] {
    CBCS_K_MEM      = 3'h0,
    CBCS_K_FILL     = 3'h1,
    CBCS_K_CODE     = 3'h2,
    CBCS_K_TLB      = 3'h3,
    CBCS_K_WRBACK   = 3'h4,
    CBCS_K_IO       = 3'h5,
    CBCS_K_SPECIAL  = 3'h6,
    CBCS_K_INTACK   = 3'h7
  } cbcs_kind_t;

  typedef struct packed {
    cbcs_kind_t           kind;
    logic                 write;
    logic                 burst;
    logic                 aliasHit;
    logic                 inquiry;
    logic [ADDR_W-1:0]    addr;
    logic [BE_W-1:0]      byteEn;
    logic [DATA_W-1:0]    data;
  } cbcs_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              cacheable;
    logic              writeBack;
    logic              last;
  } cbcs_rsp_t;

  typedef struct packed {
    logic              addressStrobe;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0]   byteEn;
    logic              memIo;
    logic              dataCode;
    logic              writeRead;
  } cbcs_addr_t;
endpackage

// file: cbcs_sequencer.sv
// Bus cycle sequencer: single, burst, pipelined, special and locked cycles
// Operation
// RULE1 - Strobe starts cycle; sample ready until done
// RULE2 - Fastest single cycle takes two clocks
// RULE3 - Inactive ready is a wait state
// RULE4 - Bursts stay in one 32-byte line
// RULE5 - Write data driven clock after strobe
// RULE6 - Only first burst address is driven
// RULE7 - Memory returns fill in toggled order
// RULE8 - Write bursts use ascending addresses
// RULE9 - Byte-wide code mode forbids code bursts
// RULE10 - Strobe every second clock, max three
// RULE11 - Next-address sampled from clock after strobe
// RULE12 - Pipeline needs request, compatibility, no holds
// RULE13 - Fill behind fill only on alias
// RULE14 - No pipelined data cycle while locked
// RULE15 - IO, special, intack only when idle
// RULE16 - Cacheability sampled at next-address or ready
// RULE17 - Inquiry write-back pipelines only with flush
// RULE18 - Idle clock between read and write bursts
// RULE19 - Next-address never changes write data
// RULE20 - Interrupt acknowledges run as locked pair
// RULE21 - Special cycle is mem0 code0 write1
// RULE22 - Byte enables carry special cycle type
// RULE23 - Special cycle ends with one ready
// RULE24 - Reset clears count, strobe stays idle
module cbcs_sequencer
  import cbcs_pkg::*;
#(
  parameter int DEPTH = cbcs_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  // Core request stream
  input  wire logic                      reqValid,
  output logic                           reqReady,
  input  wire cbcs_pkg::cbcs_req_t       req,
  // Core controls
  input  wire logic                      byte_wide_code_mode,
  input  wire logic                      lockReq,
  // Response to core
  output logic                           rspValid,
  output cbcs_pkg::cbcs_rsp_t            rsp,
  // Bus outputs
  output cbcs_pkg::cbcs_addr_t           busAddr,
  output logic                           address_strobe_n,
  output logic                           bus_lock_n,
  // Data bus, three-signal form; enable low while driving
  output logic [cbcs_pkg::DATA_W-1:0]    dataOut,
  output logic                           dataOeN,
  input  wire logic [cbcs_pkg::DATA_W-1:0] dataIn,
  // Bus inputs
  input  wire logic                      transfer_ready_n,
  input  wire logic                      next_address_req_n,
  input  wire logic                      cacheable_n,
  input  wire logic                      write_policy_sel,
  input  wire logic                      backoff_n,
  input  wire logic                      address_hold,
  input  wire logic                      hold,
  input  wire logic                      flush_line_n
);

  ////////////////////////////////////////////////////////////////////////////
  localparam int PW = $bits(cbcs_req_t);
  localparam int SW = 8 + DATA_W;

  // Synchronised pins: ready, next, cache, policy, backoff, address_hold, hold, flush, data
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic rst1;
  logic rstN;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst1 <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rst1 <= 1'b1;
      rstN <= rst1;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      // Idle pin levels, so no false ready, next-address or hold
      sync1 <= {8'he9, {DATA_W{1'b0}}};
      sync2 <= {8'he9, {DATA_W{1'b0}}};
    end else begin
      sync1 <= {transfer_ready_n, next_address_req_n, cacheable_n,
                write_policy_sel, backoff_n, address_hold, hold,
                flush_line_n, dataIn};
      sync2 <= sync1;
    end
  end

  logic readyIn;
  logic nextIn;
  logic cacheIn;
  logic policyIn;
  logic holdsActive;
  logic flushIn;
  logic [DATA_W-1:0] dIn;
  assign readyIn     = !sync2[SW-1];
  assign nextIn      = !sync2[SW-2];
  assign cacheIn     = !sync2[SW-3];
  assign policyIn    = sync2[SW-4];
  assign holdsActive = !sync2[SW-5] || sync2[SW-6] || sync2[SW-7];
  assign flushIn     = !sync2[SW-8];
  assign dIn         = sync2[DATA_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Request buffer
  logic      pendValid;
  logic      pendTake;
  cbcs_req_t pend;

  cbcs_fifo #(.WIDTH(PW), .DEPTH(DEPTH)) reqFifo (
    .mclk     (mclk),
    .rstN     (rstN),
    .inValid  (reqValid),
    .inReady  (reqReady),
    .inData   (req),
    .outValid (pendValid),
    .outReady (pendTake),
    .outData  (pend)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outstanding cycle slots, oldest at index 0
  typedef struct packed {
    cbcs_kind_t kind;
    logic       write;
    logic       burst;
    logic       gotFirst;
    logic       attrDone;
    logic       nextSeen;
    logic       cache;
    logic       policy;
    logic [1:0] beat;
    logic [DATA_W-1:0] wdata;
  } cbcs_slot_t;

  typedef struct packed {
    cbcs_slot_t [MAX_OUTSTANDING-1:0] slot;
    logic [1:0]  count;
    logic        strobeLast;
    logic        turnIdle;
    logic        lockedPairHalf;
    cbcs_addr_t  bus;
    logic        strobe;
    logic        lockOut;
    logic [DATA_W-1:0] wdata;
    logic        driveData;
    logic        rspV;
    cbcs_rsp_t   rsp;
  } cbcs_state_t;

  cbcs_state_t st;
  cbcs_state_t next_st;

  // Cycle types that only start on an idle bus
  function automatic logic isolated(input cbcs_kind_t k);
    return k == CBCS_K_IO || k == CBCS_K_SPECIAL || k == CBCS_K_INTACK;
  endfunction

  function automatic logic isData(input cbcs_kind_t k);
    return k != CBCS_K_CODE && k != CBCS_K_TLB;
  endfunction

  logic       compatible;
  logic       canStart;
  logic       doBurst;
  logic       retire;
  cbcs_slot_t head;

  assign head = st.slot[0];

  always_comb begin
    compatible = 1'b1;
    for (int i = 0; i < MAX_OUTSTANDING; i++) begin
      if (2'(i) < st.count) begin
        if (isolated(st.slot[i].kind)) compatible = 1'b0;
        if (pend.kind == CBCS_K_FILL && st.slot[i].kind == CBCS_K_FILL
            && !pend.aliasHit) compatible = 1'b0; // RULE13
      end
    end
    if (st.count != 2'h0) begin
      if (isolated(pend.kind)) compatible = 1'b0; // RULE15
      if (!st.slot[st.count-2'h1].nextSeen) compatible = 1'b0; // RULE12
      if (st.lockOut && isData(pend.kind)) compatible = 1'b0; // RULE14
      if (pend.kind == CBCS_K_WRBACK && pend.inquiry && !flushIn)
        compatible = 1'b0; // RULE17
      if (pend.write != st.slot[st.count-2'h1].write && pend.burst)
        compatible = 1'b0; // RULE18
    end
  end

  // Second intack must wait for the pair's first to retire
  assign canStart = pendValid && compatible && !holdsActive
                    && !st.strobeLast && !st.turnIdle
                    && st.count < 2'(MAX_OUTSTANDING); // RULE10 RULE12
  assign pendTake = canStart;
  assign doBurst  = pend.burst
                    && !(byte_wide_code_mode && pend.kind == CBCS_K_CODE)
                    && !isolated(pend.kind); // RULE9
  assign retire   = st.count != 2'h0 && readyIn
                    && (!head.burst || head.beat == LAST_BEAT); // RULE1 RULE3

  always_comb begin
    next_st = st;
    next_st.strobe = 1'b0;
    next_st.rspV = 1'b0;
    next_st.strobeLast = st.strobe;
    next_st.turnIdle = 1'b0;
    // Watch next-address on the youngest cycle after its strobe
    if (st.count != 2'h0 && !st.strobe && nextIn) begin
      next_st.slot[st.count-2'h1].nextSeen = 1'b1; // RULE11
      if (!st.slot[st.count-2'h1].gotFirst
          && !st.slot[st.count-2'h1].attrDone) begin
        next_st.slot[st.count-2'h1].attrDone = 1'b1; // RULE16
        next_st.slot[st.count-2'h1].cache = cacheIn;
        next_st.slot[st.count-2'h1].policy = policyIn;
      end
    end
    // Head cycle data phase
    if (st.count != 2'h0 && readyIn) begin
      next_st.rspV = !head.write;
      // Special cycle data is undefined, forwarded but not meaningful
      next_st.rsp.data = dIn; // RULE23
      next_st.rsp.cacheable = head.attrDone ? head.cache : cacheIn; // RULE16
      next_st.rsp.writeBack = head.attrDone ? head.policy : policyIn;
      next_st.rsp.last = retire;
      next_st.slot[0].gotFirst = 1'b1;
      next_st.slot[0].beat = head.beat + 2'h1; // RULE4 RULE7
    end
    if (retire) begin
      for (int i = 0; i < MAX_OUTSTANDING - 1; i++) begin
        next_st.slot[i] = next_st.slot[i+1];
      end
      next_st.slot[MAX_OUTSTANDING-1] = '0;
      next_st.count = st.count - 2'h1;
      next_st.turnIdle = head.burst;
      // Lock is only given back when the pair's second cycle retires
      if (head.kind == CBCS_K_INTACK && !st.lockedPairHalf) begin
        next_st.lockOut = lockReq; // RULE20
      end
    end
    if (st.count == 2'h0 && !st.lockedPairHalf) begin
      next_st.lockOut = lockReq;
    end
    // Data bus follows the oldest write; next-address alters nothing here
    if (next_st.count != 2'h0 && next_st.slot[0].write
        && !(st.strobe && st.count == 2'h1 && !retire)) begin
      next_st.driveData = 1'b1; // RULE5 RULE19
      next_st.wdata = next_st.slot[0].wdata;
    end else begin
      next_st.driveData = st.strobe && st.slot[0].write && st.count != 2'h0;
      next_st.wdata = st.slot[0].wdata;
    end
    if (canStart) begin
      next_st.strobe = 1'b1; // RULE1 RULE2 RULE24
      next_st.bus.addr = (pend.write && doBurst)
                         ? {pend.addr[ADDR_W-1:2], 2'h0} // RULE8
                         : pend.addr;  // RULE6
      next_st.bus.byteEn = pend.byteEn; // RULE22
      next_st.bus.memIo = !(pend.kind == CBCS_K_IO
                            || pend.kind == CBCS_K_SPECIAL
                            || pend.kind == CBCS_K_INTACK);
      next_st.bus.dataCode = pend.kind != CBCS_K_CODE
                             && pend.kind != CBCS_K_SPECIAL
                             && pend.kind != CBCS_K_INTACK;
      next_st.bus.writeRead = pend.write
                              || pend.kind == CBCS_K_SPECIAL; // RULE21
      if (pend.kind == CBCS_K_INTACK) begin
        next_st.lockOut = 1'b1; // RULE20
        next_st.lockedPairHalf = !st.lockedPairHalf;
      end
      next_st.slot[next_st.count] = '{kind: pend.kind,
        write: pend.write, burst: doBurst, gotFirst: 1'b0,
        attrDone: 1'b0, nextSeen: 1'b0, cache: 1'b0, policy: 1'b0,
        beat: 2'h0, wdata: pend.data};
      next_st.count = next_st.count + 2'h1;
    end
    next_st.bus.addressStrobe = next_st.strobe;
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      st <= '0; // RULE24
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign busAddr          = st.bus;
  assign address_strobe_n = !st.strobe;
  assign bus_lock_n       = !st.lockOut;
  assign dataOut          = st.wdata;
  assign dataOeN          = !st.driveData;
  assign rspValid         = st.rspV;
  assign rsp              = st.rsp;
endmodule

// file: cbcs_sequencer_sva.sv
// Port-level checks of the bus cycle sequencer
module cbcs_sequencer_sva
  import cbcs_pkg::*;
(
  // Clock and reset
  input wire logic                 mclk,
  input wire logic                 resetn,
  // Bus pins
  input wire logic                 address_strobe_n,
  input wire cbcs_pkg::cbcs_addr_t busAddr,
  input wire logic                 dataOeN,
  input wire logic                 transfer_ready_n,
  input wire logic                 next_address_req_n,
  input wire logic                 hold,
  // Core side
  input wire logic                 rspValid
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////////
  sequence s_start;
    !address_strobe_n;
  endsequence
  // Cycle stays outstanding and no next-address grant arrives
  sequence s_quiet;
    (transfer_ready_n && next_address_req_n) [*3];
  endsequence
  //////////////////////////////////////////////////////////////////////////
  a_strobe_pulse: assert property (
    s_start |=> address_strobe_n) else $error("strobe too long");
  a_strobe_reset: assert property (
    $rose(resetn) |-> address_strobe_n [*2]) else $error("early strobe");
  a_write_late: assert property (
    s_start and (busAddr.writeRead && $past(dataOeN)) |-> dataOeN)
    else $error("write data in strobe clock");
  a_special_code: assert property (
    s_start and (!busAddr.memIo && !busAddr.dataCode && busAddr.writeRead)
    |-> busAddr.byteEn inside {SPC_WB_INV, SPC_HALT, SPC_INV, SPC_SHUTDOWN})
    else $error("bad special code");
  a_rsp_after_ready: assert property (
    rspValid |-> $past(transfer_ready_n, 3) == 1'b0)
    else $error("response without ready");
  a_hold_blocks: assert property (
    hold [*5] |-> address_strobe_n) else $error("strobe during hold");
  a_addr_stable: assert property (
    address_strobe_n |-> $stable(busAddr.addr))
    else $error("address moved without strobe");
  a_no_na_start: assert property (
    s_start ##1 s_quiet |=> address_strobe_n)
    else $error("pipelined start without grant");
endmodule

bind cbcs_sequencer cbcs_sequencer_sva chk (.mclk(mclk), .resetn(resetn),
  .address_strobe_n(address_strobe_n), .busAddr(busAddr),
  .dataOeN(dataOeN), .transfer_ready_n(transfer_ready_n),
  .next_address_req_n(next_address_req_n), .hold(hold),
  .rspValid(rspValid));

// file: cpu_bus_cycle_sequencer_tb_top.sv
// Self-checking bench for the bus cycle sequencer
module cpu_bus_cycle_sequencer_tb_top
  import cbcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk, resetn, reqValid, reqReady, rspValid, hold;
  logic              lockReq, byteWideCode, naEn, strobeN, lockN, dataOeN;
  logic              readyN, naN, ok;
  logic [5:0]        waitN;
  cbcs_req_t         req;
  cbcs_rsp_t         rsp;
  cbcs_addr_t        busAddr;
  logic [DATA_W-1:0] dataOut, dataIn, memData, rdQ[$], wdQ[$];
  logic [39:0]       expQ[$], mskQ[$];
  int                fails, n_tests, seed, nAcc;
  cbcs_kind_t        kinds[3] = '{CBCS_K_MEM, CBCS_K_CODE, CBCS_K_TLB};
  logic [7:0]        codes[4] = '{SPC_WB_INV, SPC_HALT, SPC_INV, SPC_SHUTDOWN};
  //////////////////////////////////////////////////////////////////////////
  cbcs_sequencer dut (.mclk(mclk), .resetn(resetn), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .byte_wide_code_mode(byteWideCode),
    .lockReq(lockReq), .rspValid(rspValid), .rsp(rsp), .busAddr(busAddr),
    .address_strobe_n(strobeN), .bus_lock_n(lockN), .dataOut(dataOut),
    .dataOeN(dataOeN), .dataIn(dataIn), .transfer_ready_n(readyN),
    .next_address_req_n(naN), .cacheable_n(1'b1), .write_policy_sel(1'b0),
    .backoff_n(1'b1), .address_hold(1'b0), .hold(hold),
    .flush_line_n(1'b1));
  cbcs_mem_model mem (.mclk(mclk), .resetn(resetn),
    .address_strobe_n(strobeN), .busAddr(busAddr), .waitN(waitN),
    .naEn(naEn), .transfer_ready_n(readyN), .next_address_req_n(naN),
    .memData(memData));
  assign dataIn = dataOeN ? memData : dataOut;
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Expectations are queued before the request can reach the bus
  task automatic send(cbcs_kind_t k, logic w, logic [ADDR_W-1:0] a,
                      logic [7:0] be, int tries, output logic acc);
    acc = 1'b0;
    @(posedge mclk);
    reqValid <= 1'b1;
    req <= '{kind: k, write: w, burst: 1'b0, aliasHit: 1'b0,
             inquiry: 1'b0, addr: a, byteEn: be, data: {a, 6'h15, a}};
    for (int i = 0; i < tries && !acc; i++) begin
      @(negedge mclk);
      acc = (reqReady === 1'b1);
    end
    if (acc) begin
      expQ.push_back({be, 2'b00, w, a});
      mskQ.push_back(k == CBCS_K_SPECIAL ? 40'hffe0000000 :
                     k == CBCS_K_INTACK ? 40'h0020000000 : 40'h003fffffff);
      if (!w)
        rdQ.push_back({a, 6'h2a, ~a});
      else if (k != CBCS_K_SPECIAL)
        wdQ.push_back({a, 6'h15, a});
    end
    @(posedge mclk);
    reqValid <= 1'b0;
  endtask
  task automatic drain(string name);
    for (int i = 0; i < 4000 && expQ.size() + rdQ.size() + wdQ.size() > 0;
         i++)
      @(posedge mclk);
    repeat (8) @(posedge mclk);
    check(expQ.size() + rdQ.size() + wdQ.size(), 0);
    $display("test %s done", name);
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    logic [39:0] m;
    if (resetn) begin
      if (strobeN === 1'b0) begin
        if (expQ.size() == 0)
          check(1, 0);
        else begin
          m = mskQ.pop_front();
          check({busAddr.byteEn, busAddr.memIo, busAddr.dataCode,
                 busAddr.writeRead, busAddr.addr} & m, expQ.pop_front() & m);
        end
      end
      if (rspValid === 1'b1) begin
        check(rsp.data, rdQ.size() ? rdQ.pop_front() : ~rsp.data);
        check(rsp.last, 1'b1);
        check(rsp.cacheable, 1'b0);
      end
      if (readyN === 1'b0 && dataOeN === 1'b0 && wdQ.size() > 0)
        check(dataOut, wdQ.pop_front());
    end
  end
  initial begin
    #100000;
    fails++;
    results();
  end
  initial begin
    int k;
    logic w;
    resetn = 1'b0;
    reqValid = 1'b0;
    req = '0;
    {lockReq, byteWideCode, hold, naEn} = '0;
    waitN = '0;
    {fails, n_tests, nAcc} = '0;
    seed = 58;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    repeat (12) begin
      k = $unsigned($random(seed)) % 3;
      w = (k == 0) & 1'($random(seed));
      waitN <= 6'($unsigned($random(seed)) % 4);
      byteWideCode <= 1'($random(seed));
      send(kinds[k], w, ADDR_W'($random(seed)), BE_ALL, 50, ok);
    end
    drain("singles");
    naEn <= 1'b1;
    waitN <= 6'h2;
    repeat (8) send(CBCS_K_MEM, 1'($random(seed)),
                    ADDR_W'($random(seed)), BE_ALL, 50, ok);
    drain("pipelined");
    foreach (codes[i]) send(CBCS_K_SPECIAL, 1'b1, '0, codes[i], 50, ok);
    drain("special");
    lockReq <= 1'b1;
    send(CBCS_K_INTACK, 1'b0, '0, BE_ALL, 50, ok);
    repeat (6) @(posedge mclk);
    check(lockN, 1'b0);
    lockReq <= 1'b0;
    send(CBCS_K_INTACK, 1'b0, '0, BE_ALL, 50, ok);
    drain("intack");
    check(lockN, 1'b1);
    hold <= 1'b1;
    repeat (3) send(CBCS_K_MEM, 1'b0, ADDR_W'($random(seed)), BE_ALL, 50, ok);
    repeat (20) @(posedge mclk);
    check(expQ.size(), 3);
    hold <= 1'b0;
    drain("hold");
    naEn <= 1'b0;
    waitN <= 6'd40;
    ok = 1'b1;
    while (ok && nAcc < 64) begin
      send(CBCS_K_MEM, 1'b0, ADDR_W'($random(seed)), BE_ALL, 3, ok);
      nAcc += ok;
    end
    check(nAcc >= FIFO_DEPTH, 1);
    waitN <= 6'h0;
    drain("fill");
    results();
  end
endmodule
